// ===== core_sfr_pkg.sv
// Package of constants, field layouts and types for the core special-function block.
package core_sfr_pkg;
	localparam int PC_W = 13;
	localparam int DADDR_W = 9;
	localparam logic [12:0] PC_MASK = 13'h07ff;
	localparam logic [12:0] RESET_VEC = 13'h0000;
	localparam logic [12:0] IRQ_VEC = 13'h0004;
	localparam logic [6:0] ADDR_INDIRECT_DATA_PORT = 7'h00;
	localparam logic [6:0] ADDR_PCL = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	localparam logic [6:0] ADDR_FSR = 7'h04;
	localparam logic [6:0] ADDR_PIR = 7'h0c;
	localparam logic [6:0] ADDR_PROG_COUNTER_LATCH_HI = 7'h0a;
	localparam int ST_IRP = 7;
	localparam int ST_RP1 = 6;
	localparam int ST_RP0 = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_Z = 2;
	localparam int ST_DC = 1;
	localparam int ST_C = 0;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam int PF_ADC = 6;
	localparam int PF_SSP = 3;
	localparam int PF_CCP = 2;
	localparam int PF_TMR2 = 1;
	localparam int PF_TIMER1_COUNT = 0;
	localparam logic [7:0] PIR_MASK = 8'h4f;
	localparam logic [7:0] PIR_RST = 8'h00;
	localparam int STACK_DEPTH = 8;
	typedef enum logic [1:0] {PC_NEXT, PC_JUMP, PC_RET} pc_op_t;
endpackage : core_sfr_pkg

// ===== alu_flags_if.sv
// Interface carrying ALU operands and the resulting flags.
`timescale 1ns/100ps
interface alu_flags_if;
	logic [7:0] op_a;
	logic [7:0] op_b;
	logic sub;
	logic [7:0] result;
	logic z;
	logic dc;
	logic c;
	modport calc (input op_a, op_b, sub, output result, z, dc, c);
	modport user (output op_a, op_b, sub, input result, z, dc, c);
endinterface : alu_flags_if

// ===== alu_flags.sv
// Adder that produces the result and the zero, digit-carry and carry flags.
`timescale 1ns/100ps
module alu_flags (
	alu_flags_if.calc af
);
	import core_sfr_pkg::*;
	logic [7:0] b_eff;
	logic [4:0] low_sum;
	logic [8:0] full_sum;
	// Subtract adds the two's complement, so carries read as no-borrow.
	always_comb begin
		b_eff = af.sub ? ~af.op_b : af.op_b;
		low_sum = {1'b0, af.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, af.sub};
		full_sum = {1'b0, af.op_a} + {1'b0, b_eff} + {8'h00, af.sub};
	end
	assign af.result = full_sum[7:0];
	assign af.dc = low_sum[4];
	assign af.c = full_sum[8];
	assign af.z = (full_sum[7:0] == 8'h00);
endmodule : alu_flags

// ===== pc_stack.sv
// Hardware return stack for the program counter.
`timescale 1ns/100ps
module pc_stack (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [12:0] push_addr,
	output logic [12:0] top
);
	import core_sfr_pkg::*;
	typedef struct packed {
		logic [STACK_DEPTH-1:0][12:0] mem;
		logic [2:0] sp;
	} stk_t;
	stk_t st_ff;
	stk_t nxt_st;
	// Circular stack; overflow silently overwrites the oldest entry.
	always_comb begin
		nxt_st = st_ff;
		if (push) begin
			nxt_st.mem[st_ff.sp] = push_addr;
			nxt_st.sp = st_ff.sp + 3'h1;
		end else if (pop) begin
			nxt_st.sp = st_ff.sp - 3'h1;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign top = st_ff.mem[st_ff.sp - 3'h1];
endmodule : pc_stack

// ===== core_sfr.sv
// Core status, bank select, indirect pointer, program counter and peripheral flags.
`timescale 1ns/100ps
module core_sfr (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic [6:0] DIR_ADDR,
	input wire logic USE_INDIRECT,
	input wire logic WR_EN,
	input wire logic [7:0] WR_DATA,
	input wire logic FLAGS_AFFECTED,
	input wire logic [7:0] ALU_A,
	input wire logic [7:0] ALU_B,
	input wire logic ALU_SUB,
	input wire logic [1:0] PC_OP,
	input wire logic [10:0] JUMP_TARGET,
	input wire logic IS_CALL,
	input wire logic IRQ_ACCEPT,
	input wire logic WDT_CLEAR_INSTR,
	input wire logic SLEEP_INSTR,
	input wire logic WDT_TIMEOUT,
	input wire logic ADC_DONE,
	input wire logic SERIAL_DONE,
	input wire logic CCP_CAPTURE_MODE,
	input wire logic TIMER1_CAPTURE,
	input wire logic TIMER1_COMPARE,
	input wire logic TIMER2_MATCH,
	input wire logic TIMER1_OVERFLOW,
	input wire logic [7:0] RAM_RD_DATA,
	output logic [8:0] DATA_ADDR,
	output logic DATA_RAM_WE,
	output logic [7:0] RD_DATA,
	output logic [7:0] ALU_RESULT,
	output logic [12:0] PROG_ADDR,
	output logic [7:0] STATUS_OUT,
	output logic [7:0] PERIPH_FLAGS_OUT
);
	import core_sfr_pkg::*;
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] pointer;
		logic [7:0] latch_hi;
		logic [7:0] pflags;
		logic [12:0] pc;
	} core_t;
	core_t cs_ff;
	core_t nxt_cs;
	alu_flags_if af();
	logic [12:0] stack_top;
	logic stack_push;
	logic stack_pop;
	logic [8:0] eff_addr;
	logic [6:0] loc;
	logic is_sfr;
	logic [7:0] pflag_set;
	logic ccp_event;
	logic [12:0] pc_inc;
	assign af.op_a = ALU_A;
	assign af.op_b = ALU_B;
	assign af.sub = ALU_SUB;
	alu_flags u_alu (
		.af(af)
	);
	assign stack_push = (pc_op_t'(PC_OP) == PC_JUMP) && IS_CALL && !IRQ_ACCEPT;
	assign stack_pop = (pc_op_t'(PC_OP) == PC_RET) && !IRQ_ACCEPT;
	pc_stack u_stack (
		.clk(CLK_SYS),
		.arst_n(ARST_N),
		.push(stack_push || IRQ_ACCEPT),
		.pop(stack_pop),
		.push_addr(pc_inc),
		.top(stack_top)
	);
	// Address formation; indirect uses the pointer with its own bank bit.
	always_comb begin
		if (USE_INDIRECT) begin
			eff_addr = {cs_ff.status[ST_IRP], cs_ff.pointer};
		end else begin
			eff_addr = {cs_ff.status[ST_RP1], cs_ff.status[ST_RP0], DIR_ADDR};
		end
	end
	assign loc = eff_addr[6:0];
	// Core registers mirror into every bank except the peripheral flags.
	assign is_sfr = (loc == ADDR_INDIRECT_DATA_PORT) || (loc == ADDR_PCL) || (loc == ADDR_STATUS)
		|| (loc == ADDR_FSR) || (loc == ADDR_PROG_COUNTER_LATCH_HI)
		|| ((loc == ADDR_PIR) && (eff_addr[8:7] == 2'b00));
	// Read mux; unimplemented bits and banks come back as zero.
	always_comb begin
		RD_DATA = 8'h00;
		if (loc == ADDR_INDIRECT_DATA_PORT) begin
			RD_DATA = 8'h00;
		end else if (loc == ADDR_PCL) begin
			RD_DATA = cs_ff.pc[7:0];
		end else if (loc == ADDR_STATUS) begin
			RD_DATA = cs_ff.status;
		end else if (loc == ADDR_FSR) begin
			RD_DATA = cs_ff.pointer;
		end else if (loc == ADDR_PROG_COUNTER_LATCH_HI) begin
			RD_DATA = {3'h0, cs_ff.latch_hi[4:0]};
		end else if (is_sfr) begin
			RD_DATA = cs_ff.pflags & PIR_MASK;
		end else if (eff_addr[8] == 1'b0) begin
			RD_DATA = RAM_RD_DATA;
		end else begin
			RD_DATA = 8'h00;
		end
	end
	// Only the two implemented banks reach the RAM.
	assign DATA_RAM_WE = WR_EN && !is_sfr && (eff_addr[8] == 1'b0);
	assign ccp_event = CCP_CAPTURE_MODE ? TIMER1_CAPTURE : TIMER1_COMPARE;
	assign pflag_set = {1'b0, ADC_DONE, 2'b00, SERIAL_DONE, ccp_event, TIMER2_MATCH,
		TIMER1_OVERFLOW};
	assign pc_inc = (cs_ff.pc + 13'h0001) & PC_MASK;
	// Next state of all core registers.
	always_comb begin
		nxt_cs = cs_ff;
		if (WR_EN && loc == ADDR_STATUS) begin
			nxt_cs.status[7:5] = WR_DATA[7:5];
			if (!FLAGS_AFFECTED) begin
				nxt_cs.status[2:0] = WR_DATA[2:0];
			end
		end
		if (FLAGS_AFFECTED) begin
			nxt_cs.status[ST_Z] = af.z;
			nxt_cs.status[ST_DC] = af.dc;
			nxt_cs.status[ST_C] = af.c;
		end
		// Reset-status bits move on hardware events only.
		if (WDT_TIMEOUT) begin
			nxt_cs.status[ST_TO] = 1'b0;
		end else if (WDT_CLEAR_INSTR) begin
			nxt_cs.status[ST_TO] = 1'b1;
			nxt_cs.status[ST_PD] = 1'b1;
		end else if (SLEEP_INSTR) begin
			nxt_cs.status[ST_TO] = 1'b1;
			nxt_cs.status[ST_PD] = 1'b0;
		end
		if (WR_EN && loc == ADDR_FSR) begin
			nxt_cs.pointer = WR_DATA;
		end
		if (WR_EN && loc == ADDR_PROG_COUNTER_LATCH_HI) begin
			nxt_cs.latch_hi = {3'h0, WR_DATA[4:0]};
		end
		// Software clears flags; a same-cycle event wins over the clear.
		if (WR_EN && loc == ADDR_PIR && is_sfr) begin
			nxt_cs.pflags = WR_DATA & PIR_MASK;
		end
		nxt_cs.pflags = (nxt_cs.pflags | pflag_set) & PIR_MASK;
		// Program counter sequencing.
		if (IRQ_ACCEPT) begin
			nxt_cs.pc = IRQ_VEC;
		end else if (WR_EN && loc == ADDR_PCL) begin
			nxt_cs.pc = {cs_ff.latch_hi[4:0], WR_DATA} & PC_MASK;
		end else if (pc_op_t'(PC_OP) == PC_JUMP) begin
			nxt_cs.pc = {cs_ff.latch_hi[4:3], JUMP_TARGET} & PC_MASK;
		end else if (pc_op_t'(PC_OP) == PC_RET) begin
			nxt_cs.pc = stack_top;
		end else begin
			nxt_cs.pc = pc_inc;
		end
	end
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			cs_ff <= '{status: STATUS_RST, pointer: 8'h00, latch_hi: 8'h00,
				pflags: PIR_RST, pc: RESET_VEC};
		end else begin
			cs_ff <= nxt_cs;
		end
	end
	assign DATA_ADDR = eff_addr;
	assign ALU_RESULT = af.result;
	assign PROG_ADDR = cs_ff.pc;
	assign STATUS_OUT = cs_ff.status;
	assign PERIPH_FLAGS_OUT = cs_ff.pflags;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	irq_vector_a: assert property (IRQ_ACCEPT |=> PROG_ADDR == IRQ_VEC) else $error("irq vec");
	pc_wrap_a: assert property (PROG_ADDR[12:11] == 2'b00) else $error("pc out of range");
	flag_block_a: assert property (FLAGS_AFFECTED |=> STATUS_OUT[ST_Z] == $past(af.z))
		else $error("z not from alu");
	// Checks the zero flag against the result bus, independent of the internal flag path.
	alu_zero_a: assert property (FLAGS_AFFECTED |=>
		STATUS_OUT[ST_Z] == ($past(ALU_RESULT) == 8'h00)) else $error("zero flag wrong");
	wdt_bit_a: assert property (WDT_TIMEOUT |=> !STATUS_OUT[ST_TO]) else $error("to bit");
	sleep_bit_a: assert property (SLEEP_INSTR && !WDT_TIMEOUT && !WDT_CLEAR_INSTR |=>
		!STATUS_OUT[ST_PD]) else $error("pd bit");
	tobit_hold_a: assert property (!WDT_TIMEOUT && !WDT_CLEAR_INSTR && !SLEEP_INSTR |=>
		$stable(STATUS_OUT[ST_TO:ST_PD])) else $error("to pd changed");
	pflag_zero_a: assert property ((PERIPH_FLAGS_OUT & ~PIR_MASK) == 8'h00)
		else $error("reserved flag bit");
	pflag_set_a: assert property (TIMER1_OVERFLOW |=> PERIPH_FLAGS_OUT[PF_TIMER1_COUNT])
		else $error("flag lost");
	pcl_load_a: assert property (WR_EN && loc == ADDR_PCL && !IRQ_ACCEPT |=>
		PROG_ADDR[7:0] == $past(WR_DATA)) else $error("pcl load");
	indirect_data_port_read_a: assert property (USE_INDIRECT && cs_ff.pointer == 8'h00 |-> RD_DATA == 8'h00)
		else $error("indirect_data_port self read");
	call_c: cover property (stack_push ##[1:20] stack_pop);
	irq_c: cover property (IRQ_ACCEPT);
	sleep_c: cover property (SLEEP_INSTR ##[1:10] WDT_TIMEOUT);
endmodule : core_sfr

// ===== data_ram_model.sv
// Behavioural data RAM that stands behind the core block's data-memory bus.
`timescale 1ns/100ps
module data_ram_model (
	input wire logic clk,
	input wire logic [8:0] addr,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [512];
	// Fill that is non-zero except at 9'h0a5 and 9'h1a5, so a read that the core must mask to zero cannot pass by luck.
	initial begin
		for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'ha5;
	end
	// Reads are combinational; writes land at the clock edge.
	assign rdata = mem[addr];
	always @(posedge clk) begin
		if (we) mem[addr] <= wdata;
	end
endmodule : data_ram_model

// ===== tb_core_status_pc_indirect_addressing.sv
// Self-checking bench for the status, addressing and program counter block.
`timescale 1ns/100ps
module tb_core_status_pc_indirect_addressing;
	import core_sfr_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, use_ind = 1'b0, wr_en = 1'b0, fa = 1'b0;
	logic sub = 1'b0, is_call = 1'b0, mode = 1'b1, we;
	logic [6:0] dir = 7'h00;
	logic [7:0] wd = 8'h00, a = 8'h00, b = 8'h00, ram_rd, rd, alu_res, st_o, pf_o, st;
	logic [1:0] pc_op = 2'h0;
	logic [10:0] tgt = 11'h000;
	logic [9:0] evt = 10'h000;
	logic [8:0] daddr;
	logic [12:0] pc;
	logic [90:0] obs;
	logic [16:0] q [$];
	logic [7:0] pmap [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h40};
	int errors = 0;
	int tests_run = 0;

	core_sfr DUT (.CLK_SYS(clk), .ARST_N(arst_n), .DIR_ADDR(dir), .USE_INDIRECT(use_ind),
		.WR_EN(wr_en), .WR_DATA(wd), .FLAGS_AFFECTED(fa), .ALU_A(a), .ALU_B(b),
		.ALU_SUB(sub), .PC_OP(pc_op), .JUMP_TARGET(tgt), .IS_CALL(is_call),
		.IRQ_ACCEPT(evt[9]), .WDT_CLEAR_INSTR(evt[6]), .SLEEP_INSTR(evt[7]),
		.WDT_TIMEOUT(evt[8]), .ADC_DONE(evt[5]), .SERIAL_DONE(evt[3]),
		.CCP_CAPTURE_MODE(mode), .TIMER1_CAPTURE(evt[2]), .TIMER1_COMPARE(evt[4]),
		.TIMER2_MATCH(evt[1]), .TIMER1_OVERFLOW(evt[0]), .RAM_RD_DATA(ram_rd),
		.DATA_ADDR(daddr), .DATA_RAM_WE(we), .RD_DATA(rd), .ALU_RESULT(alu_res),
		.PROG_ADDR(pc), .STATUS_OUT(st_o), .PERIPH_FLAGS_OUT(pf_o));
	data_ram_model ram (.clk(clk), .addr(daddr), .we(we), .wdata(wd), .rdata(ram_rd));

	// Free-running 10 MHz clock.
	always #50 clk = ~clk;
	// Observed results side by side, 13 bits each, picked by the kind of a note.
	assign obs = {13'(we), 13'(alu_res), 13'(daddr), 13'(rd), pc, 13'(pf_o), 13'(st_o)};
	// Notes queued in a cycle are compared at its falling edge, when all is settled.
	always @(negedge clk) begin
		while (q.size() > 0) cmp(q.pop_front());
	end

	task automatic cmp(input logic [16:0] n);
		logic [12:0] got;
		got = obs[n[16:13] * 13 +: 13];
		tests_run++;
		if (got !== n[12:0]) begin
			errors++;
			$display("BAD %0t kind %0d got %h want %h", $time, n[16:13], got, n[12:0]);
		end
	endtask : cmp

	task automatic note(input int k, input logic [12:0] v);
		q.push_back({4'(k), v});
	endtask : note

	// Applies one access at a rising edge and leaves it standing.
	task automatic at(input logic [6:0] ad, input logic ind, w, input logic [7:0] d);
		@(posedge clk);
		dir <= ad;
		use_ind <= ind;
		wr_en <= w;
		wd <= d;
	endtask : at

	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		at(ad, 1'b0, 1'b1, d);
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic ev(input logic [9:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 10'h000;
	endtask : ev

	task automatic pcop(input logic [1:0] op, input logic [10:0] t, input logic c);
		@(posedge clk);
		pc_op <= op;
		tgt <= t;
		is_call <= c;
		@(posedge clk);
		pc_op <= PC_NEXT;
		is_call <= 1'b0;
	endtask : pcop

	// Flag-affecting operation; with w set it also targets the status register.
	task automatic alu(input logic [7:0] x, y, input logic s, w);
		logic [7:0] yb;
		logic [8:0] sum;
		logic [4:0] ln;
		yb = s ? ~y : y;
		sum = {1'b0, x} + {1'b0, yb} + 9'(s);
		ln = {1'b0, x[3:0]} + {1'b0, yb[3:0]} + 5'(s);
		@(posedge clk);
		a <= x;
		b <= y;
		sub <= s;
		fa <= 1'b1;
		wr_en <= w;
		dir <= ADDR_STATUS;
		wd <= 8'h07;
		note(5, 13'(sum[7:0]));
		@(posedge clk);
		fa <= 1'b0;
		wr_en <= 1'b0;
		st[2:0] = {sum[7:0] == 8'h00, ln[4], sum[8]};
		note(0, 13'(st));
	endtask : alu

	task automatic stop_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// Cuts a hang short; the whole sequence needs about 125 cycles.
	initial begin
		#400000;
		errors++;
		stop_test();
	end

	// Main sequence: status, flags, program counter, then addressing.
	initial begin
		void'($urandom(53030));
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		note(0, 13'h18);
		note(2, 13'h0000);
		st = 8'h18;
		wr(ADDR_STATUS, 8'h00);
		note(0, 13'h18);
		alu(8'h00, 8'h00, 1'b0, 1'b1);
		alu(8'h0f, 8'h01, 1'b0, 1'b0);
		alu(8'hff, 8'h01, 1'b0, 1'b0);
		alu(8'h05, 8'h05, 1'b1, 1'b0);
		alu(8'h10, 8'h01, 1'b1, 1'b0);
		repeat (8) alu(8'($urandom), 8'($urandom), 1'($urandom), 1'b0);
		ev(10'h100);
		st[4] = 1'b0;
		note(0, 13'(st));
		wr(ADDR_STATUS, st | 8'h18);
		note(0, 13'(st));
		ev(10'h080);
		st[4:3] = 2'b10;
		note(0, 13'(st));
		ev(10'h040);
		st[4:3] = 2'b11;
		note(0, 13'(st));
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_PIR, 8'h00);
			ev(10'h001 << i);
			note(1, 13'(pmap[i]));
		end
		ev(10'h03f);
		repeat (3) @(posedge clk);
		note(1, 13'h4f);
		wr(ADDR_PIR, 8'hff);
		note(1, 13'h4f);
		at(ADDR_PIR, 1'b0, 1'b0, 8'h00);
		note(3, 13'h4f);
		mode <= 1'b0;
		wr(ADDR_PIR, 8'h00);
		ev(10'h010);
		note(1, 13'h04);
		wr(ADDR_PROG_COUNTER_LATCH_HI, 8'h05);
		wr(ADDR_PCL, 8'h40);
		note(2, 13'h0540);
		at(ADDR_PCL, 1'b0, 1'b0, 8'h00);
		note(3, 13'h41);
		wr(ADDR_PROG_COUNTER_LATCH_HI, 8'h07);
		wr(ADDR_PCL, 8'hff);
		note(2, 13'h07ff);
		@(posedge clk);
		note(2, 13'h0000);
		wr(ADDR_PROG_COUNTER_LATCH_HI, 8'h00);
		pcop(PC_JUMP, 11'h100, 1'b0);
		note(2, 13'h0100);
		pcop(PC_JUMP, 11'h300, 1'b1);
		note(2, 13'h0300);
		pcop(PC_RET, 11'h000, 1'b0);
		note(2, 13'h0102);
		ev(10'h200);
		note(2, 13'h0004);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_STATUS, {1'b0, 2'(i), 2'b11, st[2:0]});
			at(7'h20, 1'b0, 1'b0, 8'h00);
			note(4, 13'({2'(i), 7'h20}));
		end
		wr(ADDR_STATUS, {3'b100, 2'b11, st[2:0]});
		wr(ADDR_FSR, 8'h85);
		at(ADDR_INDIRECT_DATA_PORT, 1'b1, 1'b1, 8'h5a);
		note(4, 13'h185);
		note(6, 13'h0);
		note(3, 13'h00);
		wr(ADDR_STATUS, {3'b000, 2'b11, st[2:0]});
		wr(ADDR_FSR, 8'h30);
		at(ADDR_INDIRECT_DATA_PORT, 1'b1, 1'b1, 8'h5a);
		note(4, 13'h030);
		note(6, 13'h1);
		at(ADDR_INDIRECT_DATA_PORT, 1'b1, 1'b0, 8'h00);
		note(3, 13'h5a);
		wr(ADDR_FSR, 8'h00);
		at(ADDR_INDIRECT_DATA_PORT, 1'b1, 1'b1, 8'h77);
		note(6, 13'h0);
		at(ADDR_INDIRECT_DATA_PORT, 1'b1, 1'b0, 8'h00);
		note(3, 13'h00);
		note(0, 13'(st));
		at(7'h20, 1'b0, 1'b0, 8'h00);
		@(negedge clk);
		stop_test();
	end
endmodule : tb_core_status_pc_indirect_addressing
